// *** src/shp_top.v ***
// Function
// R1 - act on settings only at mode change; the code reads the start frequency live during a homing run
// R2 - host blips idle mode to reapply
// R3 - mode 00h idle, drive unchanged
// R4 - mode 06h loads position counter
// R5 - mode 02h starts homing run
// R6 - homing frequency parameter, else default
// R7 - index 08h homing, 00h start frequency
// R8 - control bit 0 selects direction
// R9 - control bit 1 clears position at end
// R10 - bits 2..4 select homing target
// R11 - host sets direction and one target
// R12 - reference homing starts at homing frequency
// R13 - reference rising edge: decelerate to start
// R14 - left, inside: reverse until falling edge
// R15 - left, overrun: reverse, cross rise, fall
// R16 - right, inside: continue until falling edge
// R17 - right, overrun: reverse to rise, reverse, fall
// R18 - end homing at homing frequency
// R19 - end switch: stop, reverse, until inactive
// R20 - install leaves room past end switches
//
// The implementer's own choices: the address-and-strobe port and the register offsets.
`include "shp_defs.vh"

module shp_top #(
    parameter [32:0] CLK_HZ = `SHP_CLK_HZ,
    parameter [31:0] DEC_HZ = `SHP_DEC_HZ
) (
    // clock and reset
    input  wire        sys_clk,
    input  wire        rst_n,
    // register port
    input  wire [7:0]  reg_addr,
    input  wire [31:0] reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [31:0] reg_rdata,
    // switches, high when operated
    input  wire        ref_sw_in,
    input  wire        end_a_in,
    input  wire        end_b_in,
    // drive
    output reg         step_out,
    output reg         dir_out,
    output reg         run_out
);

    localparam [2:0] ST_IDLE     = 3'h0;
    localparam [2:0] ST_REF_FAST = 3'h1;
    localparam [2:0] ST_REF_DEC  = 3'h2;
    localparam [2:0] ST_REF_RISE = 3'h3;
    localparam [2:0] ST_REF_FALL = 3'h4;
    localparam [2:0] ST_END_FAST = 3'h5;
    localparam [2:0] ST_END_BACK = 3'h6;

    // software registers
    reg  [7:0]  mode_q;
    reg  [31:0] pos_set_q;
    reg  [7:0]  home_ctl_q;
    reg  [7:0]  par_idx_q;
    reg  [31:0] fstart_q;
    reg  [31:0] fhome_q;

    // motion state
    reg  [7:0]  mode_seen_q;
    reg  [7:0]  hc_act_q;
    reg  [2:0]  st_q;
    reg  [31:0] pos_q;
    reg  [31:0] freq_q;
    reg         dir_q;
    reg         flip_q;
    reg         in_pos_q;

    // switch synchronisers
    reg  [2:0]  sw_s1_q;
    reg  [2:0]  sw_s2_q;
    reg  [2:0]  sw_old_q;
    reg  [31:0] status_w;

    wire        step_pulse;
    wire        mode_chg = (mode_q != mode_seen_q);
    wire        ref_s    = sw_s2_q[2];
    wire        ref_rise = sw_s2_q[2] & ~sw_old_q[2];
    wire        ref_fall = ~sw_s2_q[2] & sw_old_q[2];
    wire        end_sel  = hc_act_q[`SHP_HC_END_B] ? sw_s2_q[1] : sw_s2_q[0];
    wire [32:0] dec_lim  = {1'b0, fstart_q} + {1'b0, DEC_HZ};
    wire        fwd      = hc_act_q[`SHP_HC_DIR];

    // homing target from the control byte, reference first
    wire        tgt_ref  = home_ctl_q[`SHP_HC_REF];
    wire        tgt_end  = home_ctl_q[`SHP_HC_END_B] | home_ctl_q[`SHP_HC_END_A];

    shp_step_gen #(
        .CLK_HZ (CLK_HZ)
    ) u_step (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .freq    (freq_q),
        .step_q  (step_pulse)
    );

    // two-stage sync of the switch pins
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sw_s1_q  <= 3'h0;
            sw_s2_q  <= 3'h0;
            sw_old_q <= 3'h0;
        end else begin
            sw_s1_q  <= {ref_sw_in, end_b_in, end_a_in};
            sw_s2_q  <= sw_s1_q;
            sw_old_q <= sw_s2_q;
        end
    end

    // register writes
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_q     <= `SHP_MODE_IDLE;
            pos_set_q  <= 32'h0000_0000;
            home_ctl_q <= 8'h00;
            par_idx_q  <= 8'h00;
            fstart_q   <= `SHP_FSTART_DEF;
            fhome_q    <= `SHP_FHOME_DEF; // R6
        end else if (reg_wr) begin
            case (reg_addr)
                `SHP_A_MODE:     mode_q     <= reg_wdata[7:0];
                `SHP_A_POS_SET:  pos_set_q  <= reg_wdata;
                `SHP_A_HOME_CTL: home_ctl_q <= reg_wdata[7:0];
                `SHP_A_PAR_IDX:  par_idx_q  <= reg_wdata[7:0];
                `SHP_A_PAR_VAL: begin
                    if (par_idx_q == `SHP_PAR_FSTART)
                        fstart_q <= reg_wdata; // R7
                    if (par_idx_q == `SHP_PAR_FHOME)
                        fhome_q <= reg_wdata; // R7
                end
                default: ;
            endcase
        end
    end

    // status word
    always @* begin
        status_w                  = 32'h0000_0000;
        status_w[`SHP_ST_RUN]     = (freq_q != 32'h0000_0000);
        status_w[`SHP_ST_DIR]     = dir_q;
        status_w[`SHP_ST_INPOS]   = in_pos_q;
        status_w[`SHP_ST_BUSY]    = (st_q != ST_IDLE);
        status_w[`SHP_ST_SW_A]    = sw_s2_q[0];
        status_w[`SHP_ST_SW_B]    = sw_s2_q[1];
        status_w[`SHP_ST_SW_REF]  = sw_s2_q[2];
    end

    // register reads, data in the following cycle
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            case (reg_addr)
                `SHP_A_MODE:     reg_rdata <= {24'h00_0000, mode_q};
                `SHP_A_POS_SET:  reg_rdata <= pos_set_q;
                `SHP_A_PAR_IDX:  reg_rdata <= {24'h00_0000, par_idx_q};
                `SHP_A_PAR_VAL: begin
                    if (par_idx_q == `SHP_PAR_FSTART)
                        reg_rdata <= fstart_q;
                    else if (par_idx_q == `SHP_PAR_FHOME)
                        reg_rdata <= fhome_q;
                    else
                        reg_rdata <= 32'h0000_0000;
                end
                `SHP_A_ACT_POS:  reg_rdata <= pos_q;
                `SHP_A_ACT_FREQ: reg_rdata <= freq_q;
                `SHP_A_STATUS:   reg_rdata <= status_w;
                default:         reg_rdata <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

    // mode change detection, homing sequencer, position counter
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_seen_q <= `SHP_MODE_IDLE;
            hc_act_q    <= 8'h00;
            st_q        <= ST_IDLE;
            pos_q       <= 32'h0000_0000;
            freq_q      <= 32'h0000_0000;
            dir_q       <= 1'b0;
            flip_q      <= 1'b0;
            in_pos_q    <= 1'b0;
        end else begin
            mode_seen_q <= mode_q; // R1
            // position follows every issued step
            if (step_pulse) begin
                if (dir_q)
                    pos_q <= pos_q + 32'h0000_0001;
                else
                    pos_q <= pos_q - 32'h0000_0001;
            end
            // a preset must not stall the sequencer and lose a switch edge
            if (mode_chg && mode_q == `SHP_MODE_SETPOS) begin
                pos_q <= pos_set_q; // R4
            end
            if (mode_chg && mode_q == `SHP_MODE_HOME) begin
                hc_act_q <= home_ctl_q; // R5
                dir_q    <= home_ctl_q[`SHP_HC_DIR]; // R8
                in_pos_q <= 1'b0;
                if (tgt_ref) begin
                    st_q   <= ST_REF_FAST; // R10
                    freq_q <= fhome_q; // R12
                end else if (tgt_end) begin
                    st_q   <= ST_END_FAST; // R10
                    freq_q <= fhome_q; // R18
                end else begin
                    st_q   <= ST_IDLE;
                    freq_q <= 32'h0000_0000;
                end
            end else begin
                // R3
                case (st_q)
                    ST_IDLE: ;
                    ST_REF_FAST: begin
                        if (ref_rise)
                            st_q <= ST_REF_DEC; // R13
                    end
                    ST_REF_DEC: begin
                        if (freq_q <= fstart_q) begin
                            freq_q <= fstart_q;
                            if (ref_s) begin
                                st_q <= ST_REF_FALL;
                                if (fwd)
                                    dir_q <= ~dir_q; // R14
                                else
                                    dir_q <= dir_q; // R16
                            end else begin
                                st_q   <= ST_REF_RISE;
                                dir_q  <= ~dir_q;
                                flip_q <= ~fwd; // R15 R17
                            end
                        end else if (step_pulse) begin
                            if ({1'b0, freq_q} > dec_lim)
                                freq_q <= freq_q - DEC_HZ; // R13
                            else
                                freq_q <= fstart_q;
                        end
                    end
                    ST_REF_RISE: begin
                        if (ref_rise) begin
                            st_q <= ST_REF_FALL; // R15
                            if (flip_q)
                                dir_q <= ~dir_q; // R17
                        end
                    end
                    ST_REF_FALL: begin
                        if (ref_fall) begin
                            st_q     <= ST_IDLE; // R14 R15 R16 R17
                            freq_q   <= 32'h0000_0000;
                            in_pos_q <= 1'b1;
                            if (hc_act_q[`SHP_HC_CLR])
                                pos_q <= 32'h0000_0000; // R9
                        end
                    end
                    ST_END_FAST: begin
                        if (end_sel) begin
                            st_q   <= ST_END_BACK; // R19
                            freq_q <= 32'h0000_0000;
                            dir_q  <= ~dir_q;
                        end
                    end
                    ST_END_BACK: begin
                        if (!end_sel) begin
                            st_q     <= ST_IDLE; // R19
                            freq_q   <= 32'h0000_0000;
                            in_pos_q <= 1'b1;
                            if (hc_act_q[`SHP_HC_CLR])
                                pos_q <= 32'h0000_0000; // R9
                        end else begin
                            freq_q <= fstart_q; // R19
                        end
                    end
                    default: begin
                        st_q   <= ST_IDLE;
                        freq_q <= 32'h0000_0000;
                    end
                endcase
            end
        end
    end

    // registered drive outputs
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            step_out <= 1'b0;
            dir_out  <= 1'b0;
            run_out  <= 1'b0;
        end else begin
            step_out <= step_pulse;
            dir_out  <= dir_q;
            run_out  <= (freq_q != 32'h0000_0000);
        end
    end

endmodule

// *** include/shp_defs.vh ***
`ifndef SHP_DEFS_VH
`define SHP_DEFS_VH

// register byte addresses
`define SHP_A_MODE      8'h00
`define SHP_A_POS_SET   8'h04
`define SHP_A_HOME_CTL  8'h08
`define SHP_A_PAR_IDX   8'h0C
`define SHP_A_PAR_VAL   8'h10
`define SHP_A_ACT_POS   8'h14
`define SHP_A_STATUS    8'h18
`define SHP_A_ACT_FREQ  8'h1C

// mode codes
`define SHP_MODE_IDLE   8'h00
`define SHP_MODE_HOME   8'h02
`define SHP_MODE_SETPOS 8'h06

// homing control bits
`define SHP_HC_DIR      0
`define SHP_HC_CLR      1
`define SHP_HC_REF      2
`define SHP_HC_END_B    3
`define SHP_HC_END_A    4

// parameter indices and defaults
`define SHP_PAR_FSTART  8'h00
`define SHP_PAR_FHOME   8'h08
`define SHP_FSTART_DEF  32'h0000_00C8
`define SHP_FHOME_DEF   32'h0000_03E8

// status bits
`define SHP_ST_RUN      0
`define SHP_ST_DIR      1
`define SHP_ST_INPOS    2
`define SHP_ST_BUSY     3
`define SHP_ST_SW_A     4
`define SHP_ST_SW_B     5
`define SHP_ST_SW_REF   6

// timing
`define SHP_CLK_HZ      33'h0_05F5_E100
`define SHP_DEC_HZ      32'h0000_0064

`endif

// *** src/shp_step_gen.v ***
`include "shp_defs.vh"

module shp_step_gen #(
    parameter [32:0] CLK_HZ = `SHP_CLK_HZ
) (
    // clock and reset
    input  wire        sys_clk,
    input  wire        rst_n,
    // rate in steps per second, zero stops
    input  wire [31:0] freq,
    // one-cycle step pulse
    output reg         step_q
);

    reg  [32:0] acc_q;
    wire [32:0] sum = acc_q + {1'b0, freq};
    wire [32:0] rem = sum - CLK_HZ;

    // phase accumulator, one step per CLK_HZ of accumulated rate
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_q  <= 33'h0_0000_0000;
            step_q <= 1'b0;
        end else if (freq == 32'h0000_0000) begin
            acc_q  <= 33'h0_0000_0000;
            step_q <= 1'b0;
        end else if (sum >= CLK_HZ) begin
            // rates above the clock saturate, no credit piles up
            acc_q  <= (rem >= CLK_HZ) ? 33'h0_0000_0000 : rem;
            step_q <= 1'b1;
        end else begin
            acc_q  <= sum;
            step_q <= 1'b0;
        end
    end

endmodule

// *** testbench/shp_top_sva.sv ***
module shp_top_sva #(
    parameter [32:0] CLK_HZ = 33'h0_05F5_E100,
    parameter [31:0] DEC_HZ = 32'h0000_0064
) (
    // clock and reset
    input wire        sys_clk,
    input wire        rst_n,
    // register port
    input wire [7:0]  reg_addr,
    input wire [31:0] reg_wdata,
    input wire        reg_wr,
    input wire        reg_rd,
    input wire [31:0] reg_rdata,
    // switches and drive
    input wire        ref_sw_in,
    input wire        end_b_in,
    input wire        step_out,
    input wire        dir_out,
    input wire        run_out
);
    timeunit 1ns;
    timeprecision 1ps;
    reg  [7:0] mode_q;
    reg  [7:0] ctl_q;
    reg  [3:0] age_q;
    wire       mode_wr = reg_wr && reg_addr == 8'h00;
    wire       start = age_q == 4'h1 && mode_q == 8'h02 && |ctl_q[4:2];
    wire       to_b = ctl_q[3] && !ctl_q[2] && run_out;
    wire       to_ref = ctl_q[2] && run_out;
    // shadows of mode and control, age of last mode change
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_q <= 8'h00;
            ctl_q <= 8'h00;
            age_q <= 4'hF;
        end else begin
            if (reg_wr && reg_addr == 8'h08) ctl_q <= reg_wdata[7:0];
            if (mode_wr) mode_q <= reg_wdata[7:0];
            if (mode_wr && reg_wdata[7:0] != mode_q) age_q <= 4'h0;
            else if (age_q != 4'hF) age_q <= age_q + 4'h1;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    AST_START: assert property (start |-> ##[0:4] (run_out && dir_out == ctl_q[0]))
        else $error("homing start wrong");
    AST_RATE: assert property (start |-> ##[1:8] step_out [*4])
        else $error("homing rate wrong");
    AST_CAUSE: assert property ($rose(run_out) |-> age_q < 4'h6 || $past(run_out, 2))
        else $error("drive started without mode change");
    AST_IDLE: assert property (mode_q == 8'h00 && age_q > 4'h2 && !run_out && !$past(run_out)
        |-> $stable({run_out, dir_out})) else $error("drive changed in idle");
    AST_END_REV: assert property ($rose(end_b_in) && to_b
        |-> ##[1:9] (run_out && dir_out != ctl_q[0])) else $error("no reversal at end switch");
    AST_END_DONE: assert property ($fell(end_b_in) && to_b
        |-> ##[1:8] !run_out [*3]) else $error("end homing did not finish");
    AST_REF_SLOW: assert property ($rose(ref_sw_in) && to_ref
        |-> ##[1:30] (run_out && !step_out)) else $error("no slow down at switch");
    AST_REF_DONE: assert property (to_ref && ctl_q[0] && !dir_out && $fell(ref_sw_in)
        |-> ##[1:8] !run_out [*3]) else $error("reference homing did not finish");
    COV_END: cover property (start && ctl_q[3]);
    COV_REF: cover property (start && ctl_q[2]);
    COV_RD: cover property (reg_rd ##1 reg_rdata != 32'h0);
endmodule
bind shp_top shp_top_sva #(.CLK_HZ(CLK_HZ), .DEC_HZ(DEC_HZ)) shp_top_sva_inst (.sys_clk, .rst_n,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .ref_sw_in, .end_b_in, .step_out,
    .dir_out, .run_out);

// *** testbench/shp_host.sv ***
module shp_host (
    // clock
    input  wire         sys_clk,
    // register port
    output logic [7:0]  reg_addr = 8'h00,
    output logic [31:0] reg_wdata = 32'h0,
    output logic        reg_wr = 1'b0,
    output logic        reg_rd = 1'b0,
    input  wire  [31:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    // one-cycle write, idle lines scrambled after
    task automatic wr(input [7:0] a, input [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask
    // one-cycle read, data taken a cycle later
    task automatic rd(input [7:0] a, output [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        @(posedge sys_clk);
        d = reg_rdata;
    endtask
    // settings only taken on a real mode change
    task automatic set_mode(input [7:0] m);
        wr(8'h00, 32'h0);
        wr(8'h00, {24'h0, m});
    endtask
endmodule

// *** testbench/tb_top.sv ***
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    reg         sys_clk = 1'b0;
    reg         rst_n = 1'b0;
    reg         ref_sw_in = 1'b0;
    reg         end_a_in = 1'b0;
    reg         end_b_in = 1'b0;
    reg  [31:0] v;
    wire [7:0]  reg_addr;
    wire [31:0] reg_wdata;
    wire [31:0] reg_rdata;
    wire        reg_wr;
    wire        reg_rd;
    wire        step_out;
    wire        dir_out;
    wire        run_out;
    int         fail_count = 0;
    int         total_checks = 0;
    int         cyc = 0;
    int         step_net = 0;
    int         base = 0;
    always #5 sys_clk = ~sys_clk;
    shp_top #(.CLK_HZ(33'h0_0000_03E8)) shp_top_inst (.sys_clk, .rst_n, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .ref_sw_in, .end_a_in, .end_b_in, .step_out, .dir_out,
        .run_out);
    shp_host shp_host_inst (.sys_clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
    task automatic chk(input string n, input [31:0] seen, input [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic w(input [7:0] a, input [31:0] d);
        shp_host_inst.wr(a, d);
    endtask
    task automatic r(input [7:0] a, input [31:0] exp);
        shp_host_inst.rd(a, v);
        chk("reg", v, exp);
    endtask
    // wait, then compare run and direction
    task automatic pins(input int n, input [1:0] exp);
        repeat (n) @(posedge sys_clk);
        chk("run dir", {30'h0, run_out, dir_out}, {30'h0, exp});
    endtask
    task automatic test_done;
        $display("checks %0d bad %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // cuts a hung run short
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 2000) begin
            fail_count++;
            test_done;
        end
    end
    // far-side step tally, signed by direction
    always @(posedge sys_clk) begin
        if (step_out)
            step_net <= dir_out ? step_net + 1 : step_net - 1;
    end
    initial begin
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'b1;
        r(8'h00, 32'h0);
        r(8'h08, 32'h0);
        r(8'hFC, 32'h0);
        w(8'h0C, 32'h8);
        r(8'h10, 32'h3E8);
        w(8'h0C, 32'h0);
        r(8'h10, 32'hC8);
        // preset, then attempt a change without mode change
        w(8'h04, 32'h8000_0001);
        shp_host_inst.set_mode(8'h06);
        r(8'h14, 32'h8000_0001);
        w(8'h04, 32'h5);
        w(8'h00, 32'h6);
        r(8'h14, 32'h8000_0001);
        w(8'h00, 32'h0);
        r(8'h14, 32'h8000_0001);
        // forward to end switch b, position cleared
        w(8'h08, 32'hB);
        shp_host_inst.set_mode(8'h02);
        pins(8, 2'b11);
        w(8'h00, 32'h0);
        r(8'h1C, 32'h3E8);
        end_b_in <= 1'b1;
        pins(10, 2'b10);
        r(8'h1C, 32'hC8);
        end_b_in <= 1'b0;
        pins(10, 2'b00);
        r(8'h14, 32'h0);
        base = step_net;
        r(8'h18, 32'h4);
        // forward to reference switch at written rate, kept
        w(8'h0C, 32'h8);
        w(8'h10, 32'h7D0);
        w(8'h08, 32'h5);
        shp_host_inst.set_mode(8'h02);
        pins(8, 2'b11);
        r(8'h1C, 32'h7D0);
        ref_sw_in <= 1'b1;
        pins(60, 2'b10);
        r(8'h1C, 32'hC8);
        ref_sw_in <= 1'b0;
        pins(10, 2'b00);
        shp_host_inst.rd(8'h14, v);
        chk("pos kept", {31'h0, v != 32'h0}, 32'h1);
        chk("pos steps", v, step_net - base);
        // backward to end switch a, position kept
        w(8'h08, 32'h10);
        shp_host_inst.set_mode(8'h02);
        pins(8, 2'b10);
        end_a_in <= 1'b1;
        pins(10, 2'b11);
        end_a_in <= 1'b0;
        pins(10, 2'b01);
        r(8'h18, 32'h6);
        r(8'h14, step_net - base);
        test_done;
    end
endmodule
